/* File: rtl/launch_pkg.sv */
// Shared constants and types for the core launch control link.
package launch_pkg;
  localparam int unsigned NUM_CORES      = 8;
  localparam int unsigned IDX_W          = 4;
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned PARAM_W        = 16;
  localparam int unsigned PARAM_LSB      = 2;
  localparam int unsigned PARAM_MSB      = 15;
  localparam int unsigned NATIVE_LONGS   = 496;
  localparam int unsigned COPY_CNT_W     = 9;
  localparam int unsigned FRAME_LONGS    = 4;
  localparam logic [3:0]  MAX_CORE_IDX   = 4'h7;
  localparam logic [3:0]  FAIL_IDX       = 4'hF;
  localparam logic [8:0]  NATIVE_LAST    = 9'h1EF;
  localparam logic [8:0]  FRAME_LAST     = 9'h003;
  localparam logic [15:0] PARAM_RST      = 16'h0000;

  typedef enum logic [1:0] {
    OP_TARGETED,
    OP_FREE,
    OP_HALT
  } launch_op_t;
endpackage

/* File: rtl/launch_if.sv */
// Request and answer link between the requesting core and the launch hub.
interface launch_if;
  import launch_pkg::*;
  logic              req_valid;
  logic              req_ready;
  launch_pkg::launch_op_t req_op;
  logic              req_script;
  logic [3:0]        req_core;
  logic [15:0]       req_addr;
  logic [15:0]       req_value;
  logic              rsp_valid;
  logic              rsp_has_result;
  logic [3:0]        rsp_core;

  modport hub
  (
    input  req_valid,
    output req_ready,
    input  req_op,
    input  req_script,
    input  req_core,
    input  req_addr,
    input  req_value,
    output rsp_valid,
    output rsp_has_result,
    output rsp_core
  );

  modport requester
  (
    output req_valid,
    input  req_ready,
    output req_op,
    output req_script,
    output req_core,
    output req_addr,
    output req_value,
    input  rsp_valid,
    input  rsp_has_result,
    input  rsp_core
  );
endinterface

/* File: rtl/launch_hub.sv */
// Hub end: picks, halts, loads and starts one of eight cores per request.
module launch_hub
  import launch_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Link to the requesting core.
  launch_if.hub                      link,
  // Shared memory access for code copy and stack frame.
  output logic                       mem_rd_r,
  output logic                       mem_wr_r,
  output logic [15:0]                mem_addr_r,
  output logic [31:0]                mem_wdata_r,
  input  wire logic [31:0]           mem_rdata,
  // Per-core local memory load port.
  output logic                       core_load_r,
  output logic [2:0]                 core_sel_r,
  output logic [8:0]                 core_load_addr_r,
  output logic [31:0]                core_load_data_r,
  // Per-core control.
  output logic [NUM_CORES-1:0]       core_run_r,
  output logic [NUM_CORES-1:0]       core_clk_en_r,
  output logic [NUM_CORES-1:0]       core_script_r,
  output logic [NUM_CORES*16-1:0]    core_param_r,
  output logic [NUM_CORES*16-1:0]    core_stack_r
);
  import launch_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_COPY_RD,
    ST_COPY_WR,
    ST_FRAME,
    ST_START,
    ST_ANSWER
  } hub_state_t;

  hub_state_t          state_r, state_nxt;
  logic [2:0]          tgt_r, tgt_nxt;
  logic                script_r, script_nxt;
  logic                has_res_r, has_res_nxt;
  logic [15:0]         addr_r, addr_nxt;
  logic [15:0]         value_r, value_nxt;
  logic [8:0]          cnt_r, cnt_nxt;
  logic                free_found;
  logic [2:0]          free_idx;
  logic                ready_nxt, rsp_v_nxt;
  logic [3:0]          rsp_core_nxt;
  logic                rd_nxt, wr_nxt, ld_nxt;
  logic [15:0]         maddr_nxt;
  logic [31:0]         wdata_nxt, ld_data_nxt;
  logic [8:0]          ld_addr_nxt;
  logic [NUM_CORES-1:0]    run_nxt, script_c_nxt;
  logic [NUM_CORES*16-1:0] param_nxt, stack_nxt;
  logic                rsp_has_res_r, rsp_v_r, ready_r;
  logic [3:0]          rsp_core_r;

  // Lowest dormant core wins; evaluated in the same cycle the request is taken.
  always_comb
  begin
    free_found = 1'b0;
    free_idx   = 3'h0;
    for (int i = NUM_CORES - 1; i >= 0; i--)
    begin
      if (!core_run_r[i])
      begin
        free_found = 1'b1;
        free_idx   = 3'(i);
      end
    end
  end

  always_comb
  begin
    state_nxt    = state_r;
    tgt_nxt      = tgt_r;
    script_nxt   = script_r;
    has_res_nxt  = has_res_r;
    addr_nxt     = addr_r;
    value_nxt    = value_r;
    cnt_nxt      = cnt_r;
    ready_nxt    = 1'b0;
    rsp_v_nxt    = 1'b0;
    rsp_core_nxt = rsp_core_r;
    rd_nxt       = 1'b0;
    wr_nxt       = 1'b0;
    ld_nxt       = 1'b0;
    maddr_nxt    = mem_addr_r;
    wdata_nxt    = mem_wdata_r;
    ld_addr_nxt  = core_load_addr_r;
    ld_data_nxt  = core_load_data_r;
    run_nxt      = core_run_r;
    script_c_nxt = core_script_r;
    param_nxt    = core_param_r;
    stack_nxt    = core_stack_r;
    unique case (state_r)
      ST_IDLE:
      begin
        ready_nxt = 1'b1;
        if (link.req_valid && ready_r)
        begin
          ready_nxt = 1'b0;
          script_nxt = link.req_script;
          addr_nxt   = link.req_addr;
          value_nxt  = link.req_value;
          cnt_nxt    = 9'h000;
          if (link.req_op == OP_HALT)
          begin
            run_nxt[link.req_core[2:0]] = 1'b0;
            rsp_v_nxt    = 1'b1;
            rsp_core_nxt = link.req_core;
            has_res_nxt  = 1'b0;
            state_nxt    = ST_ANSWER;
          end
          else if (link.req_op == OP_TARGETED && link.req_core <= MAX_CORE_IDX)
          begin
            tgt_nxt     = link.req_core[2:0];
            has_res_nxt = 1'b0;
            run_nxt[link.req_core[2:0]] = 1'b0;
            state_nxt   = link.req_script ? ST_FRAME : ST_COPY_RD;
          end
          else if (free_found)
          begin
            tgt_nxt     = free_idx;
            has_res_nxt = (link.req_op == OP_FREE);
            run_nxt[free_idx] = 1'b0;
            state_nxt   = link.req_script ? ST_FRAME : ST_COPY_RD;
          end
          else
          begin
            rsp_v_nxt    = 1'b1;
            rsp_core_nxt = FAIL_IDX;
            has_res_nxt  = (link.req_op == OP_FREE);
            state_nxt    = ST_ANSWER;
          end
        end
      end
      ST_COPY_RD:
      begin
        rd_nxt    = 1'b1;
        maddr_nxt = 16'(addr_r + {cnt_r, 2'b00});
        state_nxt = ST_COPY_WR;
      end
      ST_COPY_WR:
      begin
        ld_nxt      = 1'b1;
        ld_addr_nxt = cnt_r;
        ld_data_nxt = mem_rdata;
        cnt_nxt     = 9'(cnt_r + 9'h001);
        state_nxt   = (cnt_r == NATIVE_LAST) ? ST_START : ST_COPY_RD;
      end
      ST_FRAME:
      begin
        wr_nxt    = 1'b1;
        maddr_nxt = 16'(value_r + {cnt_r, 2'b00});
        wdata_nxt = (cnt_r == 9'h000) ? {16'h0000, addr_r} : 32'h0000_0000;
        cnt_nxt   = 9'(cnt_r + 9'h001);
        if (cnt_r == FRAME_LAST)
          state_nxt = ST_START;
      end
      ST_START:
      begin
        script_c_nxt[tgt_r] = script_r;
        if (script_r)
          stack_nxt[tgt_r*16 +: 16] = value_r;
        else
          param_nxt[tgt_r*16 +: 16] = {value_r[PARAM_MSB:PARAM_LSB], 2'b00};
        run_nxt[tgt_r] = 1'b1;
        rsp_v_nxt      = 1'b1;
        rsp_core_nxt   = {1'b0, tgt_r};
        state_nxt      = ST_ANSWER;
      end
      ST_ANSWER:
      begin
        ready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r          <= ST_IDLE;
      tgt_r            <= 3'h0;
      script_r         <= 1'b0;
      has_res_r        <= 1'b0;
      addr_r           <= 16'h0000;
      value_r          <= 16'h0000;
      cnt_r            <= 9'h000;
      ready_r          <= 1'b0;
      rsp_v_r          <= 1'b0;
      rsp_has_res_r    <= 1'b0;
      rsp_core_r       <= 4'h0;
      mem_rd_r         <= 1'b0;
      mem_wr_r         <= 1'b0;
      mem_addr_r       <= 16'h0000;
      mem_wdata_r      <= 32'h0000_0000;
      core_load_r      <= 1'b0;
      core_sel_r       <= 3'h0;
      core_load_addr_r <= 9'h000;
      core_load_data_r <= 32'h0000_0000;
      core_run_r       <= '0;
      core_clk_en_r    <= '0;
      core_script_r    <= '0;
      core_param_r     <= {NUM_CORES{PARAM_RST}};
      core_stack_r     <= '0;
    end
    else
    begin
      state_r          <= state_nxt;
      tgt_r            <= tgt_nxt;
      script_r         <= script_nxt;
      has_res_r        <= has_res_nxt;
      addr_r           <= addr_nxt;
      value_r          <= value_nxt;
      cnt_r            <= cnt_nxt;
      ready_r          <= ready_nxt;
      rsp_v_r          <= rsp_v_nxt;
      rsp_has_res_r    <= has_res_nxt;
      rsp_core_r       <= rsp_core_nxt;
      mem_rd_r         <= rd_nxt;
      mem_wr_r         <= wr_nxt;
      mem_addr_r       <= maddr_nxt;
      mem_wdata_r      <= wdata_nxt;
      core_load_r      <= ld_nxt;
      core_sel_r       <= tgt_nxt;
      core_load_addr_r <= ld_addr_nxt;
      core_load_data_r <= ld_data_nxt;
      core_run_r       <= run_nxt;
      core_clk_en_r    <= run_nxt;
      core_script_r    <= script_c_nxt;
      core_param_r     <= param_nxt;
      core_stack_r     <= stack_nxt;
    end
  end

  assign link.req_ready      = ready_r;
  assign link.rsp_valid      = rsp_v_r;
  assign link.rsp_has_result = rsp_has_res_r;
  assign link.rsp_core       = rsp_core_r;
endmodule

/* File: rtl/launch_requester.sv */
// Requester end: turns user launch commands into link requests.
module launch_requester
  import launch_pkg::*;
(
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // User command side.
  input  wire logic                   cmd_valid,
  input  wire launch_pkg::launch_op_t cmd_op,
  input  wire logic                   cmd_script,
  input  wire logic [3:0]             cmd_core,
  input  wire logic [15:0]            cmd_addr,
  input  wire logic [15:0]            cmd_value,
  input  wire logic                   cmd_value_is_addr,
  output logic                        cmd_ready_r,
  output logic                        done_r,
  output logic                        done_has_result_r,
  output logic [3:0]                  done_core_r,
  // Link to the hub.
  launch_if.requester                 link
);
  import launch_pkg::*;

  typedef enum logic [1:0] {
    RQ_IDLE,
    RQ_SEND,
    RQ_WAIT
  } rq_state_t;

  rq_state_t           state_r, state_nxt;
  logic                valid_r, valid_nxt;
  launch_op_t          op_r, op_nxt;
  logic                script_r, script_nxt;
  logic [3:0]          core_r, core_nxt;
  logic [15:0]         addr_r, addr_nxt;
  logic [15:0]         value_r, value_nxt;
  logic                rdy_nxt, done_nxt, dres_nxt;
  logic [3:0]          dcore_nxt;

  always_comb
  begin
    state_nxt  = state_r;
    valid_nxt  = valid_r;
    op_nxt     = op_r;
    script_nxt = script_r;
    core_nxt   = core_r;
    addr_nxt   = addr_r;
    value_nxt  = value_r;
    rdy_nxt    = 1'b0;
    done_nxt   = 1'b0;
    dres_nxt   = done_has_result_r;
    dcore_nxt  = done_core_r;
    unique case (state_r)
      RQ_IDLE:
      begin
        rdy_nxt = 1'b1;
        if (cmd_valid && cmd_ready_r)
        begin
          rdy_nxt    = 1'b0;
          op_nxt     = cmd_op;
          script_nxt = cmd_script;
          core_nxt   = cmd_core;
          addr_nxt   = cmd_addr;
          // A plain value travels shifted left two, limited to 14 bits.
          value_nxt  = (cmd_value_is_addr || cmd_script) ? cmd_value
                       : {cmd_value[13:0], 2'b00};
          valid_nxt  = 1'b1;
          state_nxt  = RQ_SEND;
        end
      end
      RQ_SEND:
      begin
        if (link.req_ready)
        begin
          valid_nxt = 1'b0;
          state_nxt = RQ_WAIT;
        end
      end
      RQ_WAIT:
      begin
        if (link.rsp_valid)
        begin
          done_nxt  = 1'b1;
          dres_nxt  = link.rsp_has_result;
          dcore_nxt = link.rsp_core;
          rdy_nxt   = 1'b1;
          state_nxt = RQ_IDLE;
        end
      end
      default:
      begin
        state_nxt = RQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r           <= RQ_IDLE;
      valid_r           <= 1'b0;
      op_r              <= OP_TARGETED;
      script_r          <= 1'b0;
      core_r            <= 4'h0;
      addr_r            <= 16'h0000;
      value_r           <= 16'h0000;
      cmd_ready_r       <= 1'b0;
      done_r            <= 1'b0;
      done_has_result_r <= 1'b0;
      done_core_r       <= 4'h0;
    end
    else
    begin
      state_r           <= state_nxt;
      valid_r           <= valid_nxt;
      op_r              <= op_nxt;
      script_r          <= script_nxt;
      core_r            <= core_nxt;
      addr_r            <= addr_nxt;
      value_r           <= value_nxt;
      cmd_ready_r       <= rdy_nxt;
      done_r            <= done_nxt;
      done_has_result_r <= dres_nxt;
      done_core_r       <= dcore_nxt;
    end
  end

  assign link.req_valid  = valid_r;
  assign link.req_op     = op_r;
  assign link.req_script = script_r;
  assign link.req_core   = core_r;
  assign link.req_addr   = addr_r;
  assign link.req_value  = value_r;
endmodule

/* File: bench/launch_link_asserts.sv */
// Concurrent checks on the link between the requester and the launch hub.
module launch_link_asserts
  import launch_pkg::*;
(
  // Clock and reset.
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  // Request side.
  input wire logic                   req_valid,
  input wire logic                   req_ready,
  input wire launch_pkg::launch_op_t req_op,
  input wire logic                   req_script,
  input wire logic [3:0]             req_core,
  input wire logic [15:0]            req_addr,
  input wire logic [15:0]            req_value,
  // Answer side.
  input wire logic                   rsp_valid,
  input wire logic                   rsp_has_result,
  input wire logic [3:0]             rsp_core
);
  import launch_pkg::*;
  localparam logic [10:0] NATIVE_CYC = 11'h3E2;
  logic        take;
  launch_op_t  op_r;
  launch_op_t  op_nxt;
  logic        script_r;
  logic        script_nxt;
  logic [3:0]  core_r;
  logic [3:0]  core_nxt;
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;

  assign take = req_valid && req_ready;

  // Remembers the request in flight and counts cycles since it was taken.
  always_comb
  begin
    op_nxt     = op_r;
    script_nxt = script_r;
    core_nxt   = core_r;
    cnt_nxt    = cnt_r;
    if (take)
    begin
      op_nxt     = req_op;
      script_nxt = req_script;
      core_nxt   = req_core;
      cnt_nxt    = 11'h001;
    end
    else if (cnt_r != 11'h7FF)
      cnt_nxt = cnt_r + 11'h001;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_r     <= OP_TARGETED;
      script_r <= 1'b0;
      core_r   <= 4'h0;
      cnt_r    <= 11'h7FF;
    end
    else
    begin
      op_r     <= op_nxt;
      script_r <= script_nxt;
      core_r   <= core_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_take_drops_ready: assert property (take |=> !req_ready && !req_valid)
    else $error("ready or valid still high after a take");
  a_req_held: assert property (req_valid && !req_ready |=> req_valid && $stable(req_op)
    && $stable(req_core) && $stable(req_value) && $stable(req_addr))
    else $error("request changed before it was taken");
  a_rsp_pulse: assert property (rsp_valid |-> !req_ready ##1 (req_ready && !rsp_valid))
    else $error("answer not a single pulse followed by ready");
  a_halt_echo: assert property (take && req_op == OP_HALT |=> rsp_valid && !rsp_has_result
    && rsp_core == $past(req_core))
    else $error("halt answer wrong");
  a_free_result: assert property (rsp_valid && op_r == OP_FREE |-> rsp_has_result
    && (rsp_core <= MAX_CORE_IDX || rsp_core == FAIL_IDX))
    else $error("free launch answer out of range");
  a_targeted_quiet: assert property (rsp_valid && op_r == OP_TARGETED |-> !rsp_has_result)
    else $error("targeted launch reported a result");
  a_target_exact: assert property (rsp_valid && op_r == OP_TARGETED && core_r <= MAX_CORE_IDX
    |-> rsp_core == core_r)
    else $error("targeted launch started another core");
  a_script_time: assert property (take && req_op == OP_TARGETED && req_script
    && req_core <= MAX_CORE_IDX |=> !rsp_valid [*5] ##1 rsp_valid)
    else $error("script launch answer not six cycles after take");
  a_native_time: assert property (rsp_valid && op_r != OP_HALT && !script_r
    && rsp_core != FAIL_IDX |-> cnt_r == NATIVE_CYC)
    else $error("native launch answer time wrong");
endmodule

/* File: bench/core_launch_control_tb.sv */
// Self-checking bench: requester and hub joined by the link, driven from the command side.
module core_launch_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import launch_pkg::*;
  typedef struct packed {logic has; logic [3:0] core; logic chk;} note_t;
  logic clk_sys, rst_n, cmd_valid, cmd_script, cmd_value_is_addr, cmd_ready_r;
  launch_op_t cmd_op;
  logic [3:0] cmd_core, done_core_r, cur_tgt;
  logic [15:0] cmd_addr, cmd_value, mem_addr_r, cur_addr, cur_value;
  logic done_r, done_has_result_r, mem_rd_r, mem_wr_r, core_load_r;
  logic [31:0] mem_wdata_r, mem_rdata, core_load_data_r, seed;
  logic [2:0] core_sel_r;
  logic [8:0] core_load_addr_r;
  logic [7:0] core_run_r, core_clk_en_r, core_script_r, run_m;
  logic [127:0] core_param_r, core_stack_r;
  int bad_count, n_tests, cyc, wcnt, lcnt;
  note_t notes[$];

  function automatic logic [31:0] memf(input logic [15:0] a);
    return {~a, a ^ 16'h5A3C};
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  launch_if launch_if_i();
  launch_requester launch_requester_i(.clk_sys, .rst_n, .cmd_valid, .cmd_op, .cmd_script,
    .cmd_core, .cmd_addr, .cmd_value, .cmd_value_is_addr, .cmd_ready_r, .done_r,
    .done_has_result_r, .done_core_r, .link(launch_if_i));
  launch_hub launch_hub_i(.clk_sys, .rst_n, .link(launch_if_i), .mem_rd_r, .mem_wr_r,
    .mem_addr_r, .mem_wdata_r, .mem_rdata, .core_load_r, .core_sel_r, .core_load_addr_r,
    .core_load_data_r, .core_run_r, .core_clk_en_r, .core_script_r, .core_param_r,
    .core_stack_r);
  launch_link_asserts launch_link_asserts_i(.clk_sys, .rst_n,
    .req_valid(launch_if_i.req_valid), .req_ready(launch_if_i.req_ready),
    .req_op(launch_if_i.req_op), .req_script(launch_if_i.req_script),
    .req_core(launch_if_i.req_core), .req_addr(launch_if_i.req_addr),
    .req_value(launch_if_i.req_value), .rsp_valid(launch_if_i.rsp_valid),
    .rsp_has_result(launch_if_i.rsp_has_result), .rsp_core(launch_if_i.rsp_core));

  assign mem_rdata = memf(mem_addr_r);

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Counts: tests=%0d errors=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Results, frame writes and code loads are compared as they appear.
  always @(posedge clk_sys)
  begin
    note_t n;
    if (done_r === 1'b1)
    begin
      n = notes.pop_front();
      check(32'(done_has_result_r), 32'(n.has));
      if (n.chk)
        check(32'(done_core_r), 32'(n.core));
    end
    if (mem_wr_r === 1'b1)
    begin
      check(32'(mem_addr_r), 32'(16'(cur_value + 16'(4 * wcnt))));
      check(mem_wdata_r, (wcnt == 0) ? {16'h0000, cur_addr} : 32'h0000_0000);
      wcnt++;
    end
    if (mem_rd_r === 1'b1)
      check(32'(mem_addr_r), 32'(16'(cur_addr + 16'(4 * lcnt))));
    if (core_load_r === 1'b1)
    begin
      check(core_load_data_r, memf(cur_addr + 16'(4 * core_load_addr_r)));
      check(32'(core_load_addr_r), 32'(lcnt));
      check(32'(core_sel_r), 32'(cur_tgt));
      lcnt++;
    end
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end

  task automatic launch(input launch_op_t op, input logic scr, input logic [3:0] c,
                        input logic is_addr);
    logic [3:0] tgt;
    int i;
    seed = xs(seed);
    cur_addr = seed[15:0];
    cur_value = scr ? (seed[31:16] & 16'hFFFC) : seed[31:16];
    wcnt = 0;
    lcnt = 0;
    tgt = FAIL_IDX;
    if (op == OP_HALT || (op == OP_TARGETED && c <= MAX_CORE_IDX))
      tgt = c;
    else
      for (i = 7; i >= 0; i--)
        if (!run_m[i])
          tgt = 4'(i);
    notes.push_back('{op == OP_FREE, tgt, !(op == OP_TARGETED && c > MAX_CORE_IDX)});
    cur_tgt = tgt;
    @(negedge clk_sys);
    for (i = 0; i < 2000 && cmd_ready_r !== 1'b1; i++)
      @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_script = scr;
    cmd_core = c;
    cmd_addr = cur_addr;
    cmd_value = cur_value;
    cmd_value_is_addr = is_addr;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (i = 0; i < 1200 && done_r !== 1'b1; i++)
      @(negedge clk_sys);
    check(32'(i < 1200), 32'h1);
    if (op == OP_HALT)
      run_m[tgt[2:0]] = 1'b0;
    else if (tgt != FAIL_IDX)
      run_m[tgt[2:0]] = 1'b1;
    check(32'(core_run_r), 32'(run_m));
    check(32'(core_clk_en_r), 32'(run_m));
    if (op != OP_HALT && tgt != FAIL_IDX && !scr)
    begin
      check(32'(core_param_r[int'(tgt[2:0]) * 16 +: 16]),
            32'(is_addr ? (cur_value & 16'hFFFC) : {cur_value[13:0], 2'h0}));
      check(lcnt, NATIVE_LONGS);
    end
    if (op != OP_HALT && tgt != FAIL_IDX && scr)
    begin
      check(wcnt, FRAME_LONGS);
      check(32'(core_stack_r[int'(tgt[2:0]) * 16 +: 16]), 32'(cur_value));
    end
    if (op != OP_HALT && tgt != FAIL_IDX)
      check(32'(core_script_r[tgt[2:0]]), 32'(scr));
  endtask

  initial
  begin
    {rst_n, cmd_valid, cmd_script, cmd_value_is_addr} = 4'h0;
    {cmd_core, cmd_addr, cmd_value} = 36'h0;
    cmd_op = OP_TARGETED;
    {bad_count, n_tests, cyc} = 96'h0;
    seed = 32'hA920;
    run_m = 8'h00;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    launch(OP_FREE, 1'b0, 4'h0, 1'b0);
    launch(OP_TARGETED, 1'b1, 4'h3, 1'b1);
    launch(OP_TARGETED, 1'b0, 4'h3, 1'b1);
    launch(OP_TARGETED, 1'b1, 4'hC, 1'b1);
    repeat (6) launch(OP_FREE, 1'b1, 4'h0, 1'b1);
    launch(OP_HALT, 1'b0, 4'h5, 1'b0);
    launch(OP_FREE, 1'b1, 4'h0, 1'b1);
    launch(OP_HALT, 1'b0, 4'h0, 1'b0);
    launch(OP_TARGETED, 1'b1, 4'h0, 1'b1);
    @(negedge clk_sys);
    rst_n = 1'b0;
    @(negedge clk_sys);
    rst_n = 1'b1;
    run_m = 8'h00;
    check(32'(core_run_r), 32'h0);
    launch(OP_FREE, 1'b0, 4'h0, 1'b1);
    end_sim();
  end
endmodule
